/* File: rtl/csf_map.svh */
// csf_map.svh: bit layout, reset values and shift counts of the two status words
// assumes: included by the status-word logic and its datapath shaper
`ifndef CSF_MAP_SVH
`define CSF_MAP_SVH

// status_word_zero layout
`define CSF_ST0_ARP_MSB   15
`define CSF_ST0_ARP_LSB   13
`define CSF_ST0_OV_BIT    12
`define CSF_ST0_OVM_BIT   11
`define CSF_ST0_GLOBAL_IRQ_MASK_BIT  9
`define CSF_ST0_DP_MSB    8
`define CSF_ST0_DP_LSB    0
`define CSF_ST0_RSVD      16'h0400

// status_word_one layout
`define CSF_ST1_ARB_MSB   15
`define CSF_ST1_ARB_LSB   13
`define CSF_ST1_CNF_BIT   12
`define CSF_ST1_TC_BIT    11
`define CSF_ST1_SXM_BIT   10
`define CSF_ST1_C_BIT     9
`define CSF_ST1_XF_BIT    4
`define CSF_ST1_PM_MSB    1
`define CSF_ST1_PM_LSB    0
`define CSF_ST1_RSVD      16'h01ec

// reset values
`define CSF_RST_AUX       3'h0
`define CSF_RST_DP        9'h000
`define CSF_RST_PM        2'h0
`define CSF_RST_C         1'b1
`define CSF_RST_GLOBAL_IRQ_MASK      1'b1
`define CSF_RST_SXM       1'b1
`define CSF_RST_XF        1'b1
`define CSF_RST_CNF       1'b0
`define CSF_RST_OV        1'b0
`define CSF_RST_OVM       1'b0
`define CSF_RST_TC        1'b0
`define CSF_RST_WORD      16'h0000

// product shift modes and amounts
`define CSF_PM_NONE       2'h0
`define CSF_PM_LEFT1      2'h1
`define CSF_PM_LEFT4      2'h2
`define CSF_PM_RIGHT6     2'h3
`define CSF_SH_LEFT1      1
`define CSF_SH_LEFT4      4
`define CSF_SH_RIGHT6     6
`define CSF_SCALE_MAX     5'h10

// direct addressing
`define CSF_DIR_OFS_MSB   6

// aux compare conditions
`define CSF_CMP_EQ        2'h0
`define CSF_CMP_LT        2'h1
`define CSF_CMP_GT        2'h2
`define CSF_CMP_NE        2'h3

`endif

/* File: rtl/csf_pkg.sv */
// csf_pkg: instruction and flag selector types for the status words
// assumes: the decoder drives one csf_op_t per cycle
package csf_pkg;
  typedef enum logic [3:0] {
    CSF_OP_NONE,
    CSF_OP_LOAD_ST0,
    CSF_OP_LOAD_ST1,
    CSF_OP_STORE_ST0,
    CSF_OP_STORE_ST1,
    CSF_OP_SET_FLAG,
    CSF_OP_CLEAR_FLAG,
    CSF_OP_LOAD_AUX_PTR,
    CSF_OP_MODIFY_AUX,
    CSF_OP_LOAD_PAGE,
    CSF_OP_LOAD_SHIFT_SEL,
    CSF_OP_COND_BRANCH_OV
  } csf_op_t;

  typedef enum logic [2:0] {
    CSF_FLAG_CARRY,
    CSF_FLAG_RAM_MAP,
    CSF_FLAG_IRQ_MASK,
    CSF_FLAG_CLAMP,
    CSF_FLAG_SIGN_EXT,
    CSF_FLAG_TEST,
    CSF_FLAG_OUT_PIN
  } csf_flag_t;
endpackage : csf_pkg

/* File: rtl/csf_shaper.sv */
// csf_shaper: product shifter, input scaling shifter and accumulator clamp
// assumes: purely combinational, fed by the status-word mode bits
`timescale 1ns/10ps
`default_nettype none
`include "csf_map.svh"

module csf_shaper #(
  parameter int ACC_W = 32
) (
  // product path
  input  wire logic [ACC_W-1:0] i_product,
  input  wire logic [1:0]       i_shift_sel,
  output logic      [ACC_W-1:0] o_product_alu,
  // scaling path
  input  wire logic [15:0]      i_data,
  input  wire logic [4:0]       i_shift_cnt,
  input  wire logic             i_sign_ext,
  input  wire logic             i_no_extend,
  output logic      [ACC_W-1:0] o_scaled,
  // accumulator clamp
  input  wire logic [ACC_W-1:0] i_acc_raw,
  input  wire logic             i_acc_ovf,
  input  wire logic             i_ovf_neg,
  input  wire logic             i_clamp,
  output logic      [ACC_W-1:0] o_acc_next
);
  localparam logic [ACC_W-1:0] SAT_POS = {1'b0, {(ACC_W-1){1'b1}}};
  localparam logic [ACC_W-1:0] SAT_NEG = {1'b1, {(ACC_W-1){1'b0}}};

  if (ACC_W != 32) begin : g_bad_acc_w
    $error("csf_shaper: accumulator must be 32 bits");
  end

  always_comb begin
    case (i_shift_sel)
      `CSF_PM_LEFT1:  o_product_alu = i_product << `CSF_SH_LEFT1;
      `CSF_PM_LEFT4:  o_product_alu = i_product << `CSF_SH_LEFT4;
      `CSF_PM_RIGHT6: o_product_alu = $unsigned($signed(i_product) >>> `CSF_SH_RIGHT6);
      default:        o_product_alu = i_product;
    endcase
  end

  logic             ext_on;
  logic [4:0]       cnt;
  logic [ACC_W-1:0] wide;
  assign ext_on = i_sign_ext & ~i_no_extend;
  assign cnt    = (i_shift_cnt > `CSF_SCALE_MAX) ? `CSF_SCALE_MAX : i_shift_cnt;
  assign wide   = {{(ACC_W-16){ext_on & i_data[15]}}, i_data};
  assign o_scaled = wide << cnt;

  always_comb begin
    if (i_acc_ovf && i_clamp) begin
      o_acc_next = i_ovf_neg ? SAT_NEG : SAT_POS;
    end else begin
      o_acc_next = i_acc_raw;
    end
  end
endmodule : csf_shaper

`default_nettype wire

/* File: rtl/csf_status.sv */
// csf_status: the two cpu status/control words and the logic that updates them
// assumes: one decoded instruction per cycle on i_op; datapath events as strobes
`timescale 1ns/10ps
`default_nettype none
`include "csf_map.svh"

module csf_status
  import csf_pkg::*;
#(
  parameter int ACC_W = 32
) (
  // clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_nrst,
  // decoded instruction
  input  wire csf_op_t          i_op,
  input  wire csf_flag_t        i_flag_sel,
  input  wire logic [15:0]      i_op_data,
  // indirect addressing pointer update
  input  wire logic             i_ind_aux_load,
  input  wire logic [2:0]       i_ind_aux_val,
  // carry events
  input  wire logic             i_arith_upd,
  input  wire logic             i_arith_is_sub,
  input  wire logic             i_arith_shift16,
  input  wire logic             i_arith_carry,
  input  wire logic             i_shift_c_upd,
  input  wire logic             i_shift_c_val,
  // overflow events
  input  wire logic             i_alu_ovf,
  input  wire logic             i_ovf_neg,
  input  wire logic [ACC_W-1:0] i_acc_raw,
  // test events
  input  wire logic             i_bit_test,
  input  wire logic             i_bit_val,
  input  wire logic             i_aux_compare,
  input  wire logic [1:0]       i_cmp_cond,
  input  wire logic [15:0]      i_aux_sel_val,
  input  wire logic [15:0]      i_aux_reg_zero,
  input  wire logic             i_msb_align,
  input  wire logic [1:0]       i_acc_top2,
  // interrupts
  input  wire logic             i_irq_pending,
  input  wire logic             i_trap_taken,
  // direct addressing
  input  wire logic [6:0]       i_dir_offset,
  // product and scaling paths
  input  wire logic [ACC_W-1:0] i_product,
  input  wire logic [15:0]      i_scale_data,
  input  wire logic [4:0]       i_scale_cnt,
  input  wire logic             i_sum_no_extend,
  // status views
  output logic      [15:0]      o_status_word_zero,
  output logic      [15:0]      o_status_word_one,
  output logic      [15:0]      o_store_data,
  output logic                  o_store_valid,
  // mode and pointer outputs
  output logic      [2:0]       o_aux_pointer,
  output logic      [15:0]      o_direct_addr,
  output logic                  o_ram_map_program,
  output logic                  o_irq_take,
  output logic                  o_flag_out_pin,
  output logic                  o_test_flag,
  output logic                  o_carry,
  // datapath results
  output logic      [ACC_W-1:0] o_product_alu,
  output logic      [ACC_W-1:0] o_scaled,
  output logic      [ACC_W-1:0] o_acc_next
);

  if (ACC_W != 32) begin : g_bad_acc_w
    $error("csf_status: accumulator must be 32 bits");
  end

  logic [2:0] aux_pointer;
  logic [2:0] aux_pointer_backup;
  logic [8:0] page_pointer;
  logic [1:0] product_shift_sel;
  logic       sticky_range_fault;
  logic       clamp_mode;
  logic       global_irq_mask;
  logic       ram_map_select;
  logic       test_flag;
  logic       sign_extend_mode;
  logic       add_spill_bit;
  logic       flag_out_pin;

  logic is_set;
  logic is_clr;
  logic ld0;
  logic ld1;
  assign is_set = (i_op == CSF_OP_SET_FLAG);
  assign is_clr = (i_op == CSF_OP_CLEAR_FLAG);
  assign ld0    = (i_op == CSF_OP_LOAD_ST0);
  assign ld1    = (i_op == CSF_OP_LOAD_ST1);

  // true when a set/clear op names this flag
  function automatic logic flag_hit(input csf_flag_t sel, input csf_flag_t want, input logic s, input logic c);
    flag_hit = (s | c) && (sel == want);
  endfunction : flag_hit

  // aux compare condition on the selected auxiliary register
  function automatic logic cmp_true(input logic [1:0] cond, input logic [15:0] a, input logic [15:0] b);
    case (cond)
      `CSF_CMP_EQ: cmp_true = (a == b);
      `CSF_CMP_LT: cmp_true = (a < b);
      `CSF_CMP_GT: cmp_true = (a > b);
      default:     cmp_true = (a != b);
    endcase
  endfunction : cmp_true

  // auxiliary pointer and its backup
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      aux_pointer        <= `CSF_RST_AUX;
      aux_pointer_backup <= `CSF_RST_AUX;
    end else if (ld0) begin
      // no backup copy on status load
      aux_pointer <= i_op_data[`CSF_ST0_ARP_MSB:`CSF_ST0_ARP_LSB];
    end else if (ld1) begin
      aux_pointer_backup <= i_op_data[`CSF_ST1_ARB_MSB:`CSF_ST1_ARB_LSB];
      aux_pointer        <= i_op_data[`CSF_ST1_ARB_MSB:`CSF_ST1_ARB_LSB];
    end else if (i_op == CSF_OP_LOAD_AUX_PTR || i_op == CSF_OP_MODIFY_AUX) begin
      aux_pointer_backup <= aux_pointer;
      aux_pointer        <= i_op_data[2:0];
    end else if (i_ind_aux_load) begin
      aux_pointer_backup <= aux_pointer;
      aux_pointer        <= i_ind_aux_val;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      page_pointer <= `CSF_RST_DP;
    end else if (ld0) begin
      page_pointer <= i_op_data[`CSF_ST0_DP_MSB:`CSF_ST0_DP_LSB];
    end else if (i_op == CSF_OP_LOAD_PAGE) begin
      page_pointer <= i_op_data[8:0];
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      product_shift_sel <= `CSF_RST_PM;
    end else if (ld1) begin
      product_shift_sel <= i_op_data[`CSF_ST1_PM_MSB:`CSF_ST1_PM_LSB];
    end else if (i_op == CSF_OP_LOAD_SHIFT_SEL) begin
      product_shift_sel <= i_op_data[1:0];
    end
  end

  // sticky overflow; a new overflow beats any clear
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      sticky_range_fault <= `CSF_RST_OV;
    end else if (i_alu_ovf) begin
      sticky_range_fault <= 1'b1;
    end else if (ld0) begin
      sticky_range_fault <= i_op_data[`CSF_ST0_OV_BIT];
    end else if (i_op == CSF_OP_COND_BRANCH_OV) begin
      sticky_range_fault <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      clamp_mode <= `CSF_RST_OVM;
    end else if (ld0) begin
      clamp_mode <= i_op_data[`CSF_ST0_OVM_BIT];
    end else if (flag_hit(i_flag_sel, CSF_FLAG_CLAMP, is_set, is_clr)) begin
      clamp_mode <= is_set;
    end
  end

  // interrupt mask; trap set wins, status load ignored
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      global_irq_mask <= `CSF_RST_GLOBAL_IRQ_MASK;
    end else if (i_trap_taken) begin
      global_irq_mask <= 1'b1;
    end else if (flag_hit(i_flag_sel, CSF_FLAG_IRQ_MASK, is_set, is_clr)) begin
      global_irq_mask <= is_set;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      ram_map_select <= `CSF_RST_CNF;
    end else if (ld1) begin
      ram_map_select <= i_op_data[`CSF_ST1_CNF_BIT];
    end else if (flag_hit(i_flag_sel, CSF_FLAG_RAM_MAP, is_set, is_clr)) begin
      ram_map_select <= is_set;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      test_flag <= `CSF_RST_TC;
    end else if (i_bit_test) begin
      test_flag <= i_bit_val;
    end else if (i_aux_compare) begin
      test_flag <= cmp_true(i_cmp_cond, i_aux_sel_val, i_aux_reg_zero);
    end else if (i_msb_align) begin
      test_flag <= i_acc_top2[1] ^ i_acc_top2[0];
    end else if (ld1) begin
      test_flag <= i_op_data[`CSF_ST1_TC_BIT];
    end else if (flag_hit(i_flag_sel, CSF_FLAG_TEST, is_set, is_clr)) begin
      test_flag <= is_set;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      sign_extend_mode <= `CSF_RST_SXM;
    end else if (ld1) begin
      sign_extend_mode <= i_op_data[`CSF_ST1_SXM_BIT];
    end else if (flag_hit(i_flag_sel, CSF_FLAG_SIGN_EXT, is_set, is_clr)) begin
      sign_extend_mode <= is_set;
    end
  end

  // carry: arithmetic events take priority over instruction writes
  logic next_add_spill_bit;
  always_comb begin
    next_add_spill_bit = add_spill_bit;
    if (i_arith_upd) begin
      if (i_arith_shift16) begin
        // shifted forms act one way only
        if (!i_arith_is_sub && i_arith_carry) begin
          next_add_spill_bit = 1'b1;
        end else if (i_arith_is_sub && i_arith_carry) begin
          next_add_spill_bit = 1'b0;
        end
      end else begin
        next_add_spill_bit = i_arith_is_sub ? ~i_arith_carry : i_arith_carry;
      end
    end else if (i_shift_c_upd) begin
      next_add_spill_bit = i_shift_c_val;
    end else if (ld1) begin
      next_add_spill_bit = i_op_data[`CSF_ST1_C_BIT];
    end else if (flag_hit(i_flag_sel, CSF_FLAG_CARRY, is_set, is_clr)) begin
      next_add_spill_bit = is_set;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      add_spill_bit <= `CSF_RST_C;
    end else begin
      add_spill_bit <= next_add_spill_bit;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      flag_out_pin <= `CSF_RST_XF;
    end else if (ld1) begin
      flag_out_pin <= i_op_data[`CSF_ST1_XF_BIT];
    end else if (flag_hit(i_flag_sel, CSF_FLAG_OUT_PIN, is_set, is_clr)) begin
      flag_out_pin <= is_set;
    end
  end

  logic [15:0] word_zero;
  logic [15:0] word_one;
  always_comb begin
    word_zero = `CSF_ST0_RSVD;
    word_zero[`CSF_ST0_ARP_MSB:`CSF_ST0_ARP_LSB] = aux_pointer;
    word_zero[`CSF_ST0_OV_BIT]                   = sticky_range_fault;
    word_zero[`CSF_ST0_OVM_BIT]                  = clamp_mode;
    word_zero[`CSF_ST0_GLOBAL_IRQ_MASK_BIT]                 = global_irq_mask;
    word_zero[`CSF_ST0_DP_MSB:`CSF_ST0_DP_LSB]   = page_pointer;
    word_one = `CSF_ST1_RSVD;
    word_one[`CSF_ST1_ARB_MSB:`CSF_ST1_ARB_LSB]  = aux_pointer_backup;
    word_one[`CSF_ST1_CNF_BIT]                   = ram_map_select;
    word_one[`CSF_ST1_TC_BIT]                    = test_flag;
    word_one[`CSF_ST1_SXM_BIT]                   = sign_extend_mode;
    word_one[`CSF_ST1_C_BIT]                     = add_spill_bit;
    word_one[`CSF_ST1_XF_BIT]                    = flag_out_pin;
    word_one[`CSF_ST1_PM_MSB:`CSF_ST1_PM_LSB]    = product_shift_sel;
  end

  // store path, registered so the write bus sees a stable word
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_store_data  <= `CSF_RST_WORD;
      o_store_valid <= 1'b0;
    end else begin
      o_store_valid <= (i_op == CSF_OP_STORE_ST0) || (i_op == CSF_OP_STORE_ST1);
      if (i_op == CSF_OP_STORE_ST0) begin
        o_store_data <= word_zero;
      end else if (i_op == CSF_OP_STORE_ST1) begin
        o_store_data <= word_one;
      end
    end
  end

  assign o_status_word_zero = word_zero;
  assign o_status_word_one  = word_one;
  assign o_aux_pointer      = aux_pointer;
  assign o_direct_addr      = {page_pointer, i_dir_offset[`CSF_DIR_OFS_MSB:0]};
  assign o_ram_map_program  = ram_map_select;
  // mask gates maskable requests only; reset and nmi bypass this block
  assign o_irq_take         = i_irq_pending & ~global_irq_mask;
  assign o_flag_out_pin     = flag_out_pin;
  assign o_test_flag        = test_flag;
  assign o_carry            = add_spill_bit;

  csf_shaper #(
    .ACC_W(ACC_W)
  ) u_shaper (
    .i_product    (i_product),
    .i_shift_sel  (product_shift_sel),
    .o_product_alu(o_product_alu),
    .i_data       (i_scale_data),
    .i_shift_cnt  (i_scale_cnt),
    .i_sign_ext   (sign_extend_mode),
    .i_no_extend  (i_sum_no_extend),
    .o_scaled     (o_scaled),
    .i_acc_raw    (i_acc_raw),
    .i_acc_ovf    (i_alu_ovf),
    .i_ovf_neg    (i_ovf_neg),
    .i_clamp      (clamp_mode),
    .o_acc_next   (o_acc_next)
  );
endmodule : csf_status

`default_nettype wire

/* File: sim/csf_datapath_model.sv */
// csf_datapath_model: far-side datapath values for the status block
// assumes: values move 1 ns after each rising edge, before the bench drives
`timescale 1ns/10ps
`default_nettype none

module csf_datapath_model (
  // clock
  input  wire logic        i_clock,
  // datapath values
  output logic      [31:0] o_product,
  output logic      [31:0] o_acc_raw,
  output logic      [15:0] o_scale_data,
  output logic      [15:0] o_aux_sel_val,
  output logic      [15:0] o_aux_reg_zero,
  output logic      [6:0]  o_dir_offset
);
  initial begin
    {o_product, o_acc_raw, o_scale_data, o_aux_sel_val, o_aux_reg_zero, o_dir_offset} = '0;
    forever begin
      @(posedge i_clock);
      #1;
      o_product = $urandom;
      o_acc_raw = $urandom;
      o_scale_data = 16'($urandom);
      o_aux_sel_val = 16'($urandom);
      // equal operands often, else compares rarely hit
      o_aux_reg_zero = $urandom_range(1, 0) ? o_aux_sel_val : 16'($urandom);
      o_dir_offset = 7'($urandom);
    end
  end
endmodule : csf_datapath_model
`default_nettype wire

/* File: sim/csf_status_bench.sv */
// csf_status_bench: random and corner checks of the status words
// assumes: csf_status ports, partner model supplies datapath values
`timescale 1ns/10ps
`default_nettype none

module csf_status_bench;
  import csf_pkg::*;
  logic        i_clock, i_nrst, i_ind_aux_load, i_arith_upd, i_arith_is_sub, i_arith_shift16;
  logic        i_arith_carry, i_shift_c_upd, i_shift_c_val, i_alu_ovf, i_ovf_neg, i_bit_test;
  logic        i_bit_val, i_aux_compare, i_msb_align, i_irq_pending, i_trap_taken, i_sum_no_extend;
  logic        o_store_valid, o_ram_map_program, o_irq_take, o_flag_out_pin, o_test_flag, o_carry;
  logic [1:0]  i_cmp_cond, i_acc_top2;
  logic [2:0]  i_ind_aux_val, o_aux_pointer, p;
  logic [4:0]  i_scale_cnt;
  logic [6:0]  i_dir_offset;
  logic [15:0] i_op_data, i_scale_data, i_aux_sel_val, i_aux_reg_zero, d, e;
  logic [15:0] o_status_word_zero, o_status_word_one, o_store_data, o_direct_addr;
  logic [31:0] i_product, i_acc_raw, o_product_alu, o_scaled, o_acc_next, s, t;
  logic        m, x;
  csf_op_t     i_op;
  csf_flag_t   i_flag_sel;
  int          err_total, checked;
  int          pos[7] = '{25, 28, 9, 11, 26, 27, 20};

  csf_status uut (.*);
  csf_datapath_model dpm (.i_clock, .o_product(i_product), .o_acc_raw(i_acc_raw),
    .o_scale_data(i_scale_data), .o_aux_sel_val(i_aux_sel_val),
    .o_aux_reg_zero(i_aux_reg_zero), .o_dir_offset(i_dir_offset));

  initial begin
    i_clock = 0;
    forever #12.5 i_clock = ~i_clock;
  end

  function automatic logic [15:0] ew0(logic [15:0] v, logic mk);
    return {v[15:11], 1'b1, mk, v[8:0]};
  endfunction : ew0
  function automatic logic [15:0] ew1(logic [15:0] v);
    return {v[15:9], 4'hf, v[4], 2'h3, v[1:0]};
  endfunction : ew1
  function automatic logic [31:0] epm(logic [1:0] k, logic [31:0] v);
    return k == 0 ? v : k == 1 ? v << 1 : k == 2 ? v << 4 : 32'($signed(v) >>> 6);
  endfunction : epm
  function automatic logic ecmp(logic [1:0] c, logic [15:0] a, logic [15:0] b);
    return c == 0 ? a == b : c == 1 ? a < b : c == 2 ? a > b : a != b;
  endfunction : ecmp

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n = 1);
    repeat (n) @(posedge i_clock);
    #2;
  endtask : tick
  task automatic op(input csf_op_t o, input logic [15:0] v = 16'h0, input csf_flag_t f = CSF_FLAG_CARRY);
    i_op = o;
    i_op_data = v;
    i_flag_sel = f;
    tick();
    i_op = CSF_OP_NONE;
  endtask : op
  task automatic strobe();
    tick();
    {i_ind_aux_load, i_arith_upd, i_shift_c_upd, i_alu_ovf, i_bit_test, i_aux_compare} = '0;
    {i_msb_align, i_trap_taken} = '0;
  endtask : strobe
  task automatic summarize();
    if (err_total == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  initial begin
    repeat (20000) @(posedge i_clock);
    err_total++;
    summarize();
  end

  initial begin
    {i_ind_aux_load, i_arith_upd, i_arith_is_sub, i_arith_shift16, i_arith_carry, i_shift_c_upd} = '0;
    {i_shift_c_val, i_alu_ovf, i_ovf_neg, i_bit_test, i_bit_val, i_aux_compare, i_msb_align} = '0;
    {i_irq_pending, i_trap_taken, i_sum_no_extend, i_cmp_cond, i_acc_top2, i_ind_aux_val} = '0;
    {i_scale_cnt, i_op_data} = '0;
    i_op = CSF_OP_NONE;
    i_flag_sel = CSF_FLAG_CARRY;
    {err_total, checked} = '0;
    i_nrst = 0;
    void'($urandom(32'h9519bba2));
    tick(4);
    i_nrst = 1;
    chk(o_status_word_zero, 16'h0600);
    chk(o_status_word_one, 16'h07fc);
    m = 1;
    repeat (6) begin
      d = 16'($urandom);
      e = 16'($urandom);
      op(CSF_OP_LOAD_ST0, d);
      chk(o_status_word_zero, ew0(d, m));
      op(CSF_OP_LOAD_ST1, e);
      chk(o_aux_pointer, e[15:13]);
      op(CSF_OP_STORE_ST0);
      chk({o_store_valid, o_store_data}, {1'b1, ew0({e[15:13], d[12:0]}, m)});
      op(CSF_OP_STORE_ST1);
      chk(o_store_data, ew1(e));
      tick();
      chk(o_store_valid, 0);
    end
    s = {ew1(e), ew0({e[15:13], d[12:0]}, m)};
    i_irq_pending = 1;
    for (int k = 0; k < 7; k++) for (int v = 1; v >= 0; v--) begin
      op(v ? CSF_OP_SET_FLAG : CSF_OP_CLEAR_FLAG, 16'h0, csf_flag_t'(k));
      s[pos[k]] = v[0];
      chk({o_status_word_one, o_status_word_zero}, s);
      chk(o_irq_take, !s[9]);
      chk(o_ram_map_program, s[28]);
      chk(o_flag_out_pin, s[20]);
    end
    op(CSF_OP_LOAD_ST0, 16'hffff);
    chk(o_status_word_zero[9], 0);
    i_trap_taken = 1;
    strobe();
    chk(o_status_word_zero[9], 1);
    p = 3'h7;
    for (int k = 0; k < 6; k++) begin
      d = 16'($urandom);
      op(k[0] ? CSF_OP_MODIFY_AUX : CSF_OP_LOAD_AUX_PTR, d);
      chk({o_status_word_one[15:13], o_aux_pointer}, {p, d[2:0]});
      p = d[2:0];
      i_ind_aux_val = 3'($urandom);
      i_ind_aux_load = 1;
      strobe();
      chk({o_status_word_one[15:13], o_aux_pointer}, {p, i_ind_aux_val});
      p = i_ind_aux_val;
    end
    for (int k = 0; k < 16; k++) begin
      op(k[3] ? CSF_OP_SET_FLAG : CSF_OP_CLEAR_FLAG, 16'h0, CSF_FLAG_CARRY);
      {i_arith_is_sub, i_arith_shift16, i_arith_carry} = k[2:0];
      i_arith_upd = 1;
      strobe();
      x = k[0] ? !k[2] : (k[1] ? k[3] : k[2]);
      chk(o_carry, x);
      i_shift_c_val = !x;
      i_shift_c_upd = 1;
      strobe();
      chk(o_carry, !x);
    end
    op(CSF_OP_COND_BRANCH_OV);
    i_alu_ovf = 1;
    i_ovf_neg = 1'($urandom);
    op(CSF_OP_SET_FLAG, 16'h0, CSF_FLAG_CLAMP);
    chk(o_acc_next, i_ovf_neg ? 32'h80000000 : 32'h7fffffff);
    strobe();
    tick(3);
    chk(o_status_word_zero[12], 1);
    op(CSF_OP_COND_BRANCH_OV);
    chk(o_status_word_zero[12], 0);
    i_alu_ovf = 1;
    op(CSF_OP_CLEAR_FLAG, 16'h0, CSF_FLAG_CLAMP);
    chk(o_acc_next, i_acc_raw);
    strobe();
    repeat (12) begin
      t = $urandom;
      {i_bit_val, i_acc_top2, i_cmp_cond} = t[4:0];
      {i_bit_test, i_aux_compare, i_msb_align} = t[6:5] == 0 ? 3'h4 : t[6:5] == 1 ? 3'h2 : 3'h1;
      x = t[6:5] == 0 ? t[4] : t[6:5] == 1 ? ecmp(i_cmp_cond, i_aux_sel_val, i_aux_reg_zero) : ^i_acc_top2;
      strobe();
      chk(o_test_flag, x);
    end
    d = 16'($urandom);
    op(CSF_OP_LOAD_PAGE, d);
    chk(o_direct_addr, {d[8:0], i_dir_offset});
    for (int k = 0; k < 4; k++) begin
      op(CSF_OP_LOAD_SHIFT_SEL, 16'(k));
      chk(o_product_alu, epm(2'(k), i_product));
    end
    repeat (8) begin
      x = 1'($urandom);
      i_scale_cnt = 5'($urandom_range(16));
      i_sum_no_extend = 1'($urandom);
      op(x ? CSF_OP_SET_FLAG : CSF_OP_CLEAR_FLAG, 16'h0, CSF_FLAG_SIGN_EXT);
      t = (x && !i_sum_no_extend) ? {{16{i_scale_data[15]}}, i_scale_data} : {16'h0, i_scale_data};
      chk(o_scaled, t << i_scale_cnt);
    end
    i_nrst = 0;
    tick();
    i_nrst = 1;
    chk({o_status_word_one, o_status_word_zero}, 32'h07fc0600);
    tick(2);
    summarize();
  end
endmodule : csf_status_bench

bind csf_status csf_status_properties #(.ACC_W(ACC_W)) u_props (.*);
`default_nettype wire

/* File: sim/csf_status_properties.sv */
// csf_status_properties: port-level checks of the two status words
// assumes: bound to csf_status, one clock domain
`timescale 1ns/10ps
`default_nettype none
`include "csf_map.svh"

module csf_status_properties
  import csf_pkg::*;
#(
  parameter int ACC_W = 32
) (
  // clock and reset
  input wire logic             i_clock,
  input wire logic             i_nrst,
  // stimulus
  input wire csf_op_t          i_op,
  input wire logic [15:0]      i_op_data,
  input wire logic             i_trap_taken,
  input wire logic             i_alu_ovf,
  input wire logic             i_ovf_neg,
  input wire logic             i_irq_pending,
  input wire logic [6:0]       i_dir_offset,
  input wire logic [ACC_W-1:0] i_product,
  input wire logic [ACC_W-1:0] i_acc_raw,
  // observed
  input wire logic [15:0]      o_status_word_zero,
  input wire logic [15:0]      o_status_word_one,
  input wire logic [15:0]      o_store_data,
  input wire logic             o_store_valid,
  input wire logic [15:0]      o_direct_addr,
  input wire logic             o_irq_take,
  input wire logic             o_flag_out_pin,
  input wire logic [ACC_W-1:0] o_product_alu,
  input wire logic [ACC_W-1:0] o_acc_next
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  a_store_word: assert property (i_op == CSF_OP_STORE_ST1 |=>
    o_store_valid && o_store_data == $past(o_status_word_one)) else $error("store word wrong");
  a_mask_kept: assert property (i_op == CSF_OP_LOAD_ST0 && !i_trap_taken |=>
    $stable(o_status_word_zero[9])) else $error("status load moved mask");
  a_rsvd_ones: assert property ((o_status_word_zero & `CSF_ST0_RSVD) == `CSF_ST0_RSVD &&
    (o_status_word_one & `CSF_ST1_RSVD) == `CSF_ST1_RSVD) else $error("reserved bit low");
  a_backup_copy: assert property (i_op inside {CSF_OP_LOAD_AUX_PTR, CSF_OP_MODIFY_AUX} |=>
    o_status_word_one[15:13] == $past(o_status_word_zero[15:13])) else $error("backup not copied");
  a_lst_ptr: assert property (i_op == CSF_OP_LOAD_ST1 |=>
    o_status_word_zero[15:13] == $past(i_op_data[15:13])) else $error("pointer not loaded");
  a_direct_addr: assert property (o_direct_addr == {o_status_word_zero[8:0], i_dir_offset})
    else $error("direct address wrong");
  a_page_hold: assert property (!(i_op inside {CSF_OP_LOAD_ST0, CSF_OP_LOAD_PAGE}) |=>
    $stable(o_status_word_zero[8:0])) else $error("page moved");
  a_irq_gate: assert property (o_irq_take == (i_irq_pending && !o_status_word_zero[9]))
    else $error("irq gate wrong");
  a_trap_mask: assert property (i_trap_taken |=> o_status_word_zero[9])
    else $error("trap left mask clear");
  a_ov_sticky: assert property (i_alu_ovf || (o_status_word_zero[12] &&
    !(i_op inside {CSF_OP_LOAD_ST0, CSF_OP_COND_BRANCH_OV})) |=> o_status_word_zero[12])
    else $error("overflow flag lost");
  a_wrap_pass: assert property (!o_status_word_zero[11] |-> o_acc_next == i_acc_raw)
    else $error("wrap result altered");
  a_shift_right: assert property (o_status_word_one[1:0] == 2'h3 |->
    o_product_alu == ACC_W'($signed(i_product) >>> 6)) else $error("right shift wrong");
  a_pin_drive: assert property (o_flag_out_pin == o_status_word_one[4]) else $error("pin wrong");
  a_clamp_sat: assert property (o_status_word_zero[11] && i_alu_ovf |-> o_acc_next ==
    (i_ovf_neg ? {1'b1, {(ACC_W-1){1'b0}}} : {1'b0, {(ACC_W-1){1'b1}}})) else $error("clamp wrong");
endmodule : csf_status_properties
`default_nettype wire
